//--- rtl/tmr_regs.vh
// register map, field positions and reset values of the periodic timer
// assumes a 32-bit ahb-lite slave, one register per aligned word
// What this block does
// RULE1: timer count is 8-bit read/write register, cleared on every reset
// RULE2: clock is instruction rate, prescaled by 1, 4 or 16 per select field
// RULE3: count runs from 00h to period, next increment returns to 00h as match
// RULE4: period register is 8-bit read/write, reset to ffh
// RULE5: each match feeds 4-bit postscaler; flag set once every N matches
// RULE6: postscale field bits 6..3 gives ratio of field value plus one
// RULE7: run bit 2 lets counter advance; cleared it stops the timer
// RULE8: control resets to zero, bit 7 unimplemented and reads zero
// RULE9: postscaled match latched in match flag, bit 1 of irq flag register
// RULE10: match pulse exported as pwm time base
// RULE11: timer output offered to serial module as baud clock
// RULE12: match flag stays set until software clears it
// RULE13: flag sets regardless of enable bits
// RULE14: prescaler and postscaler cleared on reset and count or control write
// RULE15: interrupt request only while match flag and its enable are both set
`ifndef TMR_REGS_VH
`define TMR_REGS_VH
// register indices; each byte address is four times its index
`define TMR_IDX_FLAGS 8'h0c
`define TMR_IDX_CONTROL 8'h12
`define TMR_IDX_ENABLES 8'h8c
// count and period indices are free choices
`define TMR_IDX_COUNT 8'h14
`define TMR_IDX_PERIOD 8'h15
`define TMR_OFS_FLAGS 32'h00000030
`define TMR_OFS_CONTROL 32'h00000048
`define TMR_OFS_ENABLES 32'h00000230
`define TMR_OFS_COUNT 32'h00000050
`define TMR_OFS_PERIOD 32'h00000054
`define TMR_RST_PERIOD 8'hff
`define TMR_RST_CONTROL 7'h00
`define TMR_BIT_MATCH 1
`define TMR_BIT_RUN 2
`define TMR_PS_LO 0
`define TMR_PS_HI 1
`define TMR_POST_LO 3
`define TMR_POST_HI 6
`define TMR_INSTR_DIV 2'h3
`define TMR_PRE_MAX_1 4'h0
`define TMR_PRE_MAX_4 4'h3
`define TMR_PRE_MAX_16 4'hf
`endif

//--- rtl/tmr_prescale.v
// prescaler: instruction-rate enable and 1/4/16 division
// assumes clr comes from register writes on the same clock
`timescale 1ns/10ps
`include "tmr_regs.vh"
module tmr_prescale
(
	// clock and reset
	input wire clk,
	input wire srst,
	// control
	input wire clr,
	input wire run,
	input wire [1:0] sel,
	// tick out
	output wire tick
);
	reg [1:0] osc_div;
	reg [3:0] pre_cnt;
	wire instr_en;
	reg [3:0] pre_max;

	assign instr_en = (osc_div == `TMR_INSTR_DIV);

	always @*
	begin
		case (sel)
			2'h0: pre_max = `TMR_PRE_MAX_1;
			2'h1: pre_max = `TMR_PRE_MAX_4;
			default: pre_max = `TMR_PRE_MAX_16;
		endcase
	end

	// instruction clock is oscillator divided by four
	always @(posedge clk)
	begin
		if (srst)
			osc_div <= 2'h0;
		else
			osc_div <= osc_div + 2'h1;
	end

	always @(posedge clk)
	begin
		if (srst || clr) // RULE14
			pre_cnt <= 4'h0;
		else if (run && instr_en)
		begin
			if (pre_cnt >= pre_max) // RULE2
				pre_cnt <= 4'h0;
			else
				pre_cnt <= pre_cnt + 4'h1;
		end
	end

	assign tick = run && instr_en && (pre_cnt >= pre_max); // RULE2 RULE7
endmodule

//--- rtl/tmr_postscale.v
// postscaler: one event per ratio matches
// assumes match is a one-cycle pulse
`timescale 1ns/10ps
module tmr_postscale
(
	// clock and reset
	input wire clk,
	input wire srst,
	// control
	input wire clr,
	input wire [3:0] ratio_m1,
	input wire match,
	// event out
	output wire fire
);
	reg [3:0] post_cnt;

	always @(posedge clk)
	begin
		if (srst || clr) // RULE14
			post_cnt <= 4'h0;
		else if (match)
		begin
			if (post_cnt >= ratio_m1)
				post_cnt <= 4'h0;
			else
				post_cnt <= post_cnt + 4'h1;
		end
	end

	assign fire = match && (post_cnt >= ratio_m1); // RULE5 RULE6
endmodule

//--- rtl/tmr_top.v
// periodic 8-bit timer with prescaler, period match and postscaler
// assumes a single ahb-lite master on clk; hsel gated by the decoder
`timescale 1ns/10ps
`include "tmr_regs.vh"
module tmr_top
(
	// clock and reset
	input wire clk,
	input wire srst,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	// time base outputs
	output wire pwm_time_base,
	output wire serial_baud_tick,
	output reg [7:0] timer_count_out,
	// interrupt
	output wire irq
);
	// register state
	reg [7:0] timer_count;
	reg [7:0] timer_period;
	reg [6:0] timer_control;
	reg timer_match_flag;
	reg timer_match_enable;
	// next register values
	reg [7:0] next_count;
	reg [7:0] next_period;
	reg [6:0] next_control;
	reg next_flag;
	reg next_enable;
	reg [7:0] next_rdata;
	// write selects held for the data phase
	reg pend_flags;
	reg pend_control;
	reg pend_enables;
	reg pend_count;
	reg pend_period;
	// bus qualification
	wire addr_valid;
	wire rd_start;
	wire wr_start;
	// live address decode
	wire sel_flags;
	wire sel_control;
	wire sel_enables;
	wire sel_count;
	wire sel_period;
	// write strobes
	wire wr_flags;
	wire wr_control;
	wire wr_enables;
	wire wr_count;
	wire wr_period;
	wire scaler_clr;
	// control fields
	wire timer_run;
	wire [1:0] clock_prescale_select;
	wire [3:0] output_postscale_select;
	// timer events
	wire tick;
	wire at_period;
	wire match;
	wire fire;
	wire flag_clr;
	// read words
	wire [7:0] flags_word;
	wire [7:0] control_word;
	wire [7:0] enables_word;
	genvar bit_idx;

	// zero-wait slave, okay response only
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// a transfer starts when an active address phase meets hready
	assign addr_valid = hready && hsel && htrans[1];
	assign rd_start = addr_valid && !hwrite;
	assign wr_start = addr_valid && hwrite;

	// full-address compare, unmapped words read zero
	assign sel_flags = (haddr == `TMR_OFS_FLAGS);
	assign sel_control = (haddr == `TMR_OFS_CONTROL);
	assign sel_enables = (haddr == `TMR_OFS_ENABLES);
	assign sel_count = (haddr == `TMR_OFS_COUNT);
	assign sel_period = (haddr == `TMR_OFS_PERIOD);

	// selects only move with hready, so a stretched data phase keeps them
	always @(posedge clk)
	begin
		if (srst)
		begin
			pend_flags <= 1'b0;
			pend_control <= 1'b0;
			pend_enables <= 1'b0;
			pend_count <= 1'b0;
			pend_period <= 1'b0;
		end
		else if (hready)
		begin
			pend_flags <= wr_start && sel_flags;
			pend_control <= wr_start && sel_control;
			pend_enables <= wr_start && sel_enables;
			pend_count <= wr_start && sel_count;
			pend_period <= wr_start && sel_period;
		end
	end

	// hwdata is taken only when the data phase completes
	assign wr_flags = pend_flags && hready;
	assign wr_control = pend_control && hready;
	assign wr_enables = pend_enables && hready;
	assign wr_count = pend_count && hready;
	assign wr_period = pend_period && hready;
	assign scaler_clr = wr_count || wr_control; // RULE14

	assign timer_run = timer_control[`TMR_BIT_RUN];
	assign clock_prescale_select = timer_control[`TMR_PS_HI:`TMR_PS_LO];
	assign output_postscale_select = timer_control[`TMR_POST_HI:`TMR_POST_LO];

	tmr_prescale tmr_prescale_inst
	(
		.clk(clk),
		.srst(srst),
		.clr(scaler_clr),
		.run(timer_run),
		.sel(clock_prescale_select),
		.tick(tick)
	);

	assign at_period = (timer_count == timer_period);
	assign match = tick && at_period; // RULE3

	tmr_postscale tmr_postscale_inst
	(
		.clk(clk),
		.srst(srst),
		.clr(scaler_clr),
		.ratio_m1(output_postscale_select),
		.match(match),
		.fire(fire)
	);

	// a software write wins over a match in the same cycle
	always @*
	begin
		if (wr_count)
		begin
			next_count = hwdata[7:0]; // RULE1
		end
		else if (match)
		begin
			next_count = 8'h00; // RULE3
		end
		else if (tick)
		begin
			next_count = timer_count + 8'h01; // RULE7
		end
		else
		begin
			next_count = timer_count;
		end
	end

	always @(posedge clk)
	begin
		if (srst)
			timer_count <= 8'h00; // RULE1
		else
			timer_count <= next_count;
	end

	always @*
	begin
		if (wr_period)
		begin
			next_period = hwdata[7:0]; // RULE4
		end
		else
		begin
			next_period = timer_period;
		end
	end

	always @(posedge clk)
	begin
		if (srst)
			timer_period <= `TMR_RST_PERIOD; // RULE4
		else
			timer_period <= next_period;
	end

	// bit 7 has no storage
	always @*
	begin
		if (wr_control)
		begin
			next_control = hwdata[6:0]; // RULE8
		end
		else
		begin
			next_control = timer_control;
		end
	end

	always @(posedge clk)
	begin
		if (srst)
			timer_control <= `TMR_RST_CONTROL; // RULE8
		else
			timer_control <= next_control;
	end

	always @*
	begin
		if (wr_enables)
		begin
			next_enable = hwdata[`TMR_BIT_MATCH];
		end
		else
		begin
			next_enable = timer_match_enable;
		end
	end

	always @(posedge clk)
	begin
		if (srst)
			timer_match_enable <= 1'b0;
		else
			timer_match_enable <= next_enable;
	end

	assign flag_clr = wr_flags && hwdata[`TMR_BIT_MATCH];

	// set wins over write-one-to-clear, whatever the enables say
	always @*
	begin
		if (fire)
		begin
			next_flag = 1'b1; // RULE9 RULE13
		end
		else if (flag_clr)
		begin
			next_flag = 1'b0; // RULE12
		end
		else
		begin
			next_flag = timer_match_flag;
		end
	end

	always @(posedge clk)
	begin
		if (srst)
			timer_match_flag <= 1'b0;
		else
			timer_match_flag <= next_flag;
	end

	assign irq = timer_match_flag && timer_match_enable; // RULE15
	assign pwm_time_base = match; // RULE10
	assign serial_baud_tick = match; // RULE11

	// registered copy of the count, one cycle behind
	always @(posedge clk)
	begin
		if (srst)
			timer_count_out <= 8'h00;
		else
			timer_count_out <= timer_count;
	end

	// only the match bit exists in the shared flag and enable words
	generate
		for (bit_idx = 0; bit_idx < 8; bit_idx = bit_idx + 1)
		begin : g_irq_bits
			if (bit_idx == `TMR_BIT_MATCH)
			begin : g_used
				assign flags_word[bit_idx] = timer_match_flag;
				assign enables_word[bit_idx] = timer_match_enable;
			end
			else
			begin : g_unused
				assign flags_word[bit_idx] = 1'b0;
				assign enables_word[bit_idx] = 1'b0;
			end
		end
	endgenerate
	assign control_word = {1'b0, timer_control}; // RULE8

	always @*
	begin
		next_rdata = 8'h00;
		if (sel_flags)
		begin
			next_rdata = flags_word;
		end
		else if (sel_control)
		begin
			next_rdata = control_word;
		end
		else if (sel_enables)
		begin
			next_rdata = enables_word;
		end
		else if (sel_count)
		begin
			next_rdata = timer_count;
		end
		else if (sel_period)
		begin
			next_rdata = timer_period;
		end
	end

	// read data stands through the data phase and until the next read
	always @(posedge clk)
	begin
		if (srst)
			hrdata <= 32'h00000000;
		else if (rd_start)
			hrdata <= {24'h000000, next_rdata};
	end
endmodule

//--- sim/tmr_top_monitor.sv
// assertions on the periodic timer top ports
// assumes one clock, srst synchronous active high
`timescale 1ns/10ps
module tmr_top_monitor
(
	// clock and reset
	input wire clk,
	input wire srst,
	// bus
	input wire hsel,
	input wire hwrite,
	input wire hreadyout,
	input wire hresp,
	// timer
	input wire pwm_time_base,
	input wire serial_baud_tick,
	input wire [7:0] timer_count_out,
	input wire irq
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	sequence s_zero_later;
		##2 timer_count_out == 8'h00;
	endsequence
	a_match_wraps: assert property (pwm_time_base |-> s_zero_later)
		else $error("no wrap after match");
	a_match_single: assert property (pwm_time_base |=> !pwm_time_base [*3])
		else $error("match too close");
	a_baud_same: assert property (serial_baud_tick == pwm_time_base)
		else $error("baud tick differs");
	a_tick_spacing: assert property ($changed(timer_count_out) |=> $stable(timer_count_out) [*3])
		else $error("count moved too fast");
	a_irq_cause: assert property ($rose(irq) |-> $past(pwm_time_base) || $past(hsel && hwrite, 2))
		else $error("irq rose without cause");
	a_irq_drop: assert property ($fell(irq) |-> $past(hsel && hwrite, 2))
		else $error("irq fell without write");
	a_bus_ready: assert property (hreadyout)
		else $error("wait state seen");
	a_bus_okay: assert property (!hresp)
		else $error("error response seen");
endmodule
bind tmr_top tmr_top_monitor tmr_top_monitor_inst (.clk, .srst, .hsel, .hwrite, .hreadyout,
	.hresp, .pwm_time_base, .serial_baud_tick, .timer_count_out, .irq);

//--- sim/tb_tmr_top.sv
// self-checking bench for the periodic timer top
// assumes a zero-wait slave; bench is the only master
`timescale 1ns/10ps
`include "tmr_regs.vh"
module tb_tmr_top;
	logic clk = 0, srst = 1, hsel = 0, hwrite = 0, hreadyout, hresp, pwm_time_base;
	logic serial_baud_tick, irq;
	logic [1:0] htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
	logic [7:0] timer_count_out;
	int error_cnt = 0, checked = 0, n, c, t;
	tmr_top tmr_top_inst (.clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pwm_time_base,
		.serial_baud_tick, .timer_count_out, .irq);
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	task end_sim;
		$display("errors %0d compares %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] want);
		checked++;
		if (got !== want)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		hsel <= 1'b1;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task gap(input int want);
		t = 0;
		do
		begin
			@(posedge clk);
			t++;
		end
		while (pwm_time_base !== 1'b1 && t < 2000);
		c = 0;
		do
		begin
			@(posedge clk);
			c++;
		end
		while (pwm_time_base !== 1'b1 && c < 2000);
		cmp(c, want);
	endtask
	task rd(input logic [31:0] a, input logic [31:0] want);
		bus(a, 1'b0, 32'h0);
		cmp(r, want);
	endtask
	initial
	begin
		#200000;
		error_cnt++;
		end_sim;
	end
	initial
	begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rd(`TMR_OFS_COUNT, 32'h00);
		rd(`TMR_OFS_PERIOD, 32'hff);
		rd(`TMR_OFS_CONTROL, 32'h00);
		rd(`TMR_OFS_FLAGS, 32'h00);
		bus(`TMR_OFS_CONTROL, 1'b1, 32'hff);
		rd(`TMR_OFS_CONTROL, 32'h7f);
		bus(`TMR_OFS_CONTROL, 1'b1, 32'h00);
		bus(`TMR_OFS_COUNT, 1'b1, 32'h5a);
		repeat (100) @(posedge clk);
		rd(`TMR_OFS_COUNT, 32'h5a);
		bus(32'h40, 1'b1, 32'hff);
		rd(32'h40, 32'h00);
		bus(`TMR_OFS_PERIOD, 1'b1, 32'h03);
		rd(`TMR_OFS_PERIOD, 32'h03);
		bus(`TMR_OFS_ENABLES, 1'b1, 32'h02);
		for (int i = 0; i < 4; i++)
		begin
			bus(`TMR_OFS_CONTROL, 1'b1, 32'h00);
			repeat (4) @(posedge clk);
			bus(`TMR_OFS_COUNT, 1'b1, 32'h00);
			bus(`TMR_OFS_FLAGS, 1'b1, 32'h02);
			bus(`TMR_OFS_CONTROL, 1'b1, ((i * 5) << 3) | 4 | i);
			n = 0;
			c = 0;
			t = 0;
			while (irq !== 1'b1 && t < 5000)
			begin
				@(posedge clk);
				t++;
				if (pwm_time_base === 1'b1)
				begin
					n++;
					if (n == 2)
						cmp(c, 16 * (i == 0 ? 1 : i == 1 ? 4 : 16));
				end
				if (n > 0)
					c++;
			end
			cmp(n, i * 5 + 1);
			rd(`TMR_OFS_FLAGS, 32'h02);
		end
		bus(`TMR_OFS_CONTROL, 1'b1, 32'h00);
		bus(`TMR_OFS_ENABLES, 1'b1, 32'h00);
		bus(`TMR_OFS_FLAGS, 1'b1, 32'h02);
		rd(`TMR_OFS_FLAGS, 32'h00);
		bus(`TMR_OFS_CONTROL, 1'b1, 32'h04);
		repeat (100) @(posedge clk);
		rd(`TMR_OFS_FLAGS, 32'h02);
		cmp(irq, 1'b0);
		gap(16);
		bus(`TMR_OFS_PERIOD, 1'b1, 32'h00);
		gap(4);
		end_sim;
	end
endmodule
